// ---- hdl/scs_pkg.sv ----
// Purpose: shared constants for the system clock source switcher
// Assumes: 3-bit source codes, 4-bit divider codes, 6-bit trim
// Notes: offsets, codes, divider and trim reset values and timing counts (not the relock timeout) live here
package scs_pkg;
  // ---------------------------------------------------------------
  // source codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SRC_EXT = 3'h7;
  localparam logic [2:0] SRC_HF = 3'h6;
  localparam logic [2:0] SRC_LF = 3'h5;
  localparam logic [2:0] SRC_SEC = 3'h4;
  localparam logic [2:0] SRC_RSV3 = 3'h3;
  localparam logic [2:0] SRC_EXT_PLL = 3'h2;
  localparam logic [2:0] SRC_HF_PLL = 3'h1;
  localparam logic [2:0] SRC_RSV0 = 3'h0;
  localparam int SRC_N = 8;
  // ---------------------------------------------------------------
  // divider, trim and frequency select
  // ---------------------------------------------------------------
  localparam logic [3:0] DIV_MAX = 4'h9;
  localparam logic [3:0] DIV_RST_HF = 4'h2;
  localparam logic [3:0] DIV_RST_OTHER = 4'h0;
  localparam logic [5:0] TRIM_RST = 6'h00;
  localparam logic [5:0] TRIM_MAX_UP = 6'h1f;
  localparam logic [5:0] TRIM_MAX_DOWN = 6'h20;
  localparam logic [2:0] HF_FRQ_1MHZ = 3'h0;
  localparam logic [2:0] HF_FRQ_32MHZ = 3'h6;
  localparam logic [2:0] HF_FRQ_MAX = 3'h6;
  // ---------------------------------------------------------------
  // oscillator ready/enable bit positions
  // ---------------------------------------------------------------
  localparam int OSC_EXT_BIT = 7;
  localparam int OSC_HF_BIT = 6;
  localparam int OSC_MF_BIT = 5;
  localparam int OSC_LF_BIT = 4;
  localparam int OSC_SEC_BIT = 3;
  localparam int OSC_PLL_BIT = 0;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int PLL_LOCK_NS = 2000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int MF_500K_HZ = 500000;
  localparam int MF_32K_HZ = 32000;
  localparam int LF_HZ = 31000;
  localparam int MF_500K_HALF = CLK_HZ / (2 * MF_500K_HZ);
  localparam int MF_32K_HALF = CLK_HZ / (2 * MF_32K_HZ);
  localparam int LF_HALF = CLK_HZ / (2 * LF_HZ);
endpackage : scs_pkg

// ---- hdl/scs_tick_div.sv ----
// Purpose: square-wave generator from a half-period count
// Assumes: HALF at least 1
// Notes: output is a register, free running from reset
`timescale 1ns/1ps
`default_nettype none
module scs_tick_div #(
  parameter int HALF = 25
) (
  input wire logic clk_i, // core clock
  input wire logic srst_i, // sync reset
  output logic clk_o // divided square wave
);
  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt_reg;
  // ---------------------------------------------------------------
  // toggle every HALF cycles
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
      clk_o <= 1'b0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= '0;
      clk_o <= ~clk_o;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule : scs_tick_div
`default_nettype wire

// ---- hdl/scs_post_div.sv ----
// Purpose: glitch-free post divider enable for the system clock
// Assumes: divider code 0..9 gives ratio 2**code
// Notes: emits one-cycle enable pulses; code is compared on every cycle, not held to a period end
`timescale 1ns/1ps
`default_nettype none
module scs_post_div
  import scs_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic srst_i, // sync reset
  input wire logic run_i, // high when the system clock may run
  input wire logic [3:0] div_i, // current divider code
  output logic tick_o // one-cycle system clock enable
);
  logic [8:0] cnt_reg;
  logic [8:0] last;
  // ratio 2**code, counter wraps at ratio-1
  assign last = 9'((10'h001 << div_i) - 10'h001);
  // ---------------------------------------------------------------
  // counter: wraps at or past last, so a smaller code on a change cuts the period short
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else if (cnt_reg >= last) begin
      cnt_reg <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 9'h001;
      tick_o <= 1'b0;
    end
  end
endmodule : scs_post_div
`default_nettype wire

// ---- hdl/scs_switcher.sv ----
// Purpose: system clock source switcher with post divider and hf trim
// Assumes: oscillators are modelled by ready inputs; one core clock
// Notes: system clock is a gated enable; ready inputs are synchronised
//
// Behaviour
// - reset loads source from reset-source field
// - hf frequency from 3-bit select, max 32MHz
// - derive 500kHz and 32kHz medium sources
// - post divider ratios 1:1 up to 1:512
// - trim is 6-bit two's complement, resets 00h
// - trim writes give no completion flag
// - trim never affects low-frequency oscillator
// - provide 31kHz low-frequency source
// - per-oscillator ready status and manual enable
// - keep current clock until requested source ready
// - divider-only or running source: ready immediately
// - on ready set new-ready and irq flag
// - hold clear: switch as soon as ready
// - hold set: stay on old clock
// - in doze, switch on next clock cycle
// - divider-only change uses same handshake
// - current fields update at switch, done sets
// - pll input change: run old, enable new
// - pll relock suspends system; failure alerts monitor
// - sleep before switch drops the switch
// - wake with hold clear: new clock, flag set (code: a pll input change wakes on the old clock and requests again)
// - decode source codes; 011/000 act as 110
// - reserved request code ignores whole write
// - switch disabled: request stays at reset value
`timescale 1ns/1ps
`default_nettype none
module scs_switcher
  import scs_pkg::*;
#(
  parameter int LOCK_CYC = PLL_LOCK_CYC
) (
  input wire logic core_clk_i, // 25 MHz core clock
  input wire logic srst_i, // sync reset, active high
  input wire logic [2:0] reset_source_select_i, // config reset source
  input wire logic switch_enable_config_i, // config: request writable
  input wire logic req_wr_i, // write strobe for request fields
  input wire logic [2:0] requested_source_i, // written source code
  input wire logic [3:0] requested_divider_i, // written divider code
  input wire logic hold_wr_i, // write strobe for switch hold
  input wire logic switch_hold_i, // written switch hold value
  input wire logic irq_enable_i, // switch irq enable
  input wire logic irq_flag_clr_i, // clear switch irq flag
  input wire logic trim_wr_i, // write strobe for trim
  input wire logic [5:0] freq_trim_i, // written trim value
  input wire logic frq_wr_i, // write strobe for hf freq select
  input wire logic [2:0] hf_freq_select_i, // written hf freq select
  input wire logic [7:0] osc_manual_enable_i, // manual oscillator enables
  input wire logic [7:0] osc_ready_i, // raw ready from oscillators (async)
  input wire logic pll_lock_i, // raw pll lock (async)
  input wire logic doze_i, // cpu doze mode
  input wire logic sleep_i, // sleep request
  input wire logic wake_i, // wake event
  output logic [2:0] requested_source_o, // request source field
  output logic [3:0] requested_divider_o, // request divider field
  output logic [2:0] current_source_o, // current source field
  output logic [3:0] current_divider_o, // current divider field
  output logic switch_hold_o, // switch hold bit
  output logic new_source_ready_o, // new source ready bit
  output logic switch_done_o, // switch done bit
  output logic switch_irq_flag_o, // switch irq flag
  output logic irq_o, // switch interrupt
  output logic [5:0] freq_trim_o, // trim register
  output logic [2:0] hf_freq_o, // hf frequency select
  output logic [7:0] osc_ready_status_o, // synchronised ready status
  output logic [7:0] osc_enable_o, // oscillator enables
  output logic [2:0] sel_source_o, // decoded source feeding the clock
  output logic sys_clk_en_o, // system clock enable pulse
  output logic mf_500k_o, // medium source 500 kHz
  output logic mf_32k_o, // medium source 32 kHz
  output logic lf_31k_o, // low-frequency 31 kHz
  output logic pll_fail_o, // lock failure to fail-safe monitor
  output logic asleep_o // device in sleep
);
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_HELD, ST_GAP, ST_RELOCK, ST_SLEEP} scs_state_t;
  scs_state_t state_reg;
  logic [7:0] rdy_meta_reg;
  logic [7:0] rdy_sync_reg;
  logic lock_meta_reg;
  logic lock_sync_reg;
  logic [15:0] lock_cnt_reg;
  logic [2:0] req_dec;
  logic [2:0] cur_dec;
  logic req_ready;
  logic pll_change;
  logic req_pending;
  logic div_tick;
  logic run;
  logic [3:0] rst_div;
  logic reserved_wr;

  // ---------------------------------------------------------------
  // source decode
  // ---------------------------------------------------------------
  function automatic logic [2:0] scs_decode(input logic [2:0] code);
    if (code == SRC_RSV3 || code == SRC_RSV0) begin
      scs_decode = SRC_HF;
    end else begin
      scs_decode = code;
    end
  endfunction : scs_decode

  // ready bit of the oscillator behind a decoded source
  function automatic logic scs_src_ready(input logic [2:0] src, input logic [7:0] rdy,
                                         input logic lock);
    case (src)
      SRC_EXT: scs_src_ready = rdy[OSC_EXT_BIT];
      SRC_LF: scs_src_ready = rdy[OSC_LF_BIT];
      SRC_SEC: scs_src_ready = rdy[OSC_SEC_BIT];
      SRC_EXT_PLL: scs_src_ready = rdy[OSC_EXT_BIT] && lock;
      SRC_HF_PLL: scs_src_ready = rdy[OSC_HF_BIT] && lock;
      default: scs_src_ready = rdy[OSC_HF_BIT];
    endcase
  endfunction : scs_src_ready

  assign req_dec = scs_decode(requested_source_o);
  assign cur_dec = scs_decode(current_source_o);
  assign req_pending = (requested_source_o != current_source_o) ||
                       (requested_divider_o != current_divider_o);
  // pll kept, only its input changes
  assign pll_change = (req_dec == SRC_EXT_PLL || req_dec == SRC_HF_PLL) &&
                      (cur_dec == SRC_EXT_PLL || cur_dec == SRC_HF_PLL) &&
                      (req_dec != cur_dec);
  // same source (or divider-only) is ready at once; a pll input change
  // needs only the new input oscillator, lock comes in the relock phase
  always_comb begin
    if (req_dec == cur_dec) begin
      req_ready = 1'b1;
    end else if (pll_change) begin
      req_ready = (req_dec == SRC_EXT_PLL) ? rdy_sync_reg[OSC_EXT_BIT] :
                  rdy_sync_reg[OSC_HF_BIT];
    end else begin
      req_ready = scs_src_ready(req_dec, rdy_sync_reg, lock_sync_reg);
    end
  end
  assign rst_div = (reset_source_select_i == SRC_HF) ? DIV_RST_HF : DIV_RST_OTHER;
  assign reserved_wr = (requested_source_i == SRC_RSV3) || (requested_source_i == SRC_RSV0) ||
                       (requested_divider_i > DIV_MAX);

  // ---------------------------------------------------------------
  // input synchronisers: ready and lock come from other clocks
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdy_meta_reg <= 8'h00;
      rdy_sync_reg <= 8'h00;
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
    end else begin
      rdy_meta_reg <= osc_ready_i;
      rdy_sync_reg <= rdy_meta_reg;
      lock_meta_reg <= pll_lock_i;
      lock_sync_reg <= lock_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // request fields
  // ---------------------------------------------------------------
  // reset value is taken on a clocked edge, from the config strap
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      requested_source_o <= reset_source_select_i;
      requested_divider_o <= rst_div;
    end else if (req_wr_i && switch_enable_config_i && !reserved_wr) begin
      requested_source_o <= requested_source_i;
      requested_divider_o <= requested_divider_i;
    end
  end

  // hold bit, software owned; a wake never clears it, so a held switch stays held
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      switch_hold_o <= 1'b0;
    end else if (hold_wr_i) begin
      switch_hold_o <= switch_hold_i;
    end
  end

  // ---------------------------------------------------------------
  // switch state machine
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      current_source_o <= reset_source_select_i;
      current_divider_o <= rst_div;
      new_source_ready_o <= 1'b0;
      switch_done_o <= 1'b1;
      lock_cnt_reg <= 16'h0000;
      pll_fail_o <= 1'b0;
      asleep_o <= 1'b0;
    end else begin
      pll_fail_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (sleep_i) begin
            state_reg <= ST_SLEEP;
            asleep_o <= 1'b1;
          end else if (req_pending) begin
            state_reg <= ST_WAIT;
            switch_done_o <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (sleep_i) begin
            state_reg <= ST_SLEEP;
            asleep_o <= 1'b1;
          end else if (!req_pending) begin
            state_reg <= ST_IDLE;
            switch_done_o <= 1'b1;
          end else if (req_ready) begin
            new_source_ready_o <= 1'b1;
            state_reg <= switch_hold_o ? ST_HELD : ST_GAP;
          end
        end
        ST_HELD: begin
          // abandon by copying current into request, or resume on hold clear
          if (sleep_i) begin
            state_reg <= ST_SLEEP;
            asleep_o <= 1'b1;
            new_source_ready_o <= 1'b0;
          end else if (!req_pending) begin
            state_reg <= ST_IDLE;
            new_source_ready_o <= 1'b0;
            switch_done_o <= 1'b1;
          end else if (!req_ready) begin
            state_reg <= ST_WAIT;
            new_source_ready_o <= 1'b0;
          end else if (!switch_hold_o) begin
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin
          // one dead cycle between old and new: no runt enable pulse;
          // the switch does not wait for a cpu cycle, so doze is moot
          if (pll_change) begin
            state_reg <= ST_RELOCK;
            lock_cnt_reg <= 16'h0000;
          end else begin
            state_reg <= ST_IDLE;
            current_source_o <= requested_source_o;
            current_divider_o <= requested_divider_o;
            switch_done_o <= 1'b1;
            new_source_ready_o <= 1'b0;
          end
        end
        ST_RELOCK: begin
          // system held while the pll takes its new input
          if (lock_sync_reg && lock_cnt_reg >= 16'(LOCK_CYC)) begin
            state_reg <= ST_IDLE;
            current_source_o <= requested_source_o;
            current_divider_o <= requested_divider_o;
            switch_done_o <= 1'b1;
            new_source_ready_o <= 1'b0;
          end else if (lock_cnt_reg == 16'hffff) begin
            pll_fail_o <= 1'b1;
            lock_cnt_reg <= 16'h0000;
          end else begin
            lock_cnt_reg <= lock_cnt_reg + 16'h0001;
          end
        end
        ST_SLEEP: begin
          if (wake_i) begin
            asleep_o <= 1'b0;
            if (req_pending && !switch_hold_o && !pll_change) begin
              state_reg <= ST_IDLE;
              current_source_o <= requested_source_o;
              current_divider_o <= requested_divider_o;
              switch_done_o <= 1'b1;
            end else begin
              state_reg <= req_pending ? ST_WAIT : ST_IDLE; // old clock, request again
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // switch irq flag: a set wins over a clear in the same cycle
  // ---------------------------------------------------------------
  logic flag_set;
  assign flag_set = (state_reg == ST_WAIT && !sleep_i && req_pending && req_ready) ||
                    (state_reg == ST_SLEEP && wake_i && req_pending && !switch_hold_o &&
                     !pll_change);
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      switch_irq_flag_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      if (flag_set) begin
        switch_irq_flag_o <= 1'b1;
      end else if (irq_flag_clr_i) begin
        switch_irq_flag_o <= 1'b0;
      end
      irq_o <= irq_enable_i && (switch_irq_flag_o || flag_set);
    end
  end

  // ---------------------------------------------------------------
  // trim and hf frequency select
  // ---------------------------------------------------------------
  // trim only steers the hf oscillator; lf path never sees it, and
  // there is deliberately no settle flag for a trim write
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      freq_trim_o <= TRIM_RST;
    end else if (trim_wr_i) begin
      freq_trim_o <= freq_trim_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      hf_freq_o <= (reset_source_select_i == SRC_HF_PLL) ? HF_FRQ_32MHZ : HF_FRQ_1MHZ;
    end else if (frq_wr_i) begin
      hf_freq_o <= (hf_freq_select_i > HF_FRQ_MAX) ? HF_FRQ_MAX : hf_freq_select_i;
    end
  end

  // ---------------------------------------------------------------
  // oscillator status and enables
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      osc_ready_status_o <= 8'h00;
      osc_enable_o <= 8'h00;
      sel_source_o <= SRC_HF;
    end else begin
      osc_ready_status_o <= {rdy_sync_reg[7:1], lock_sync_reg};
      // manual enables, plus the oscillator (not the pll) behind current and requested, plus the lf oscillator always
      osc_enable_o <= osc_manual_enable_i |
                      (8'h01 << osc_bit(cur_dec)) | (8'h01 << osc_bit(req_dec)) |
                      (8'h01 << OSC_LF_BIT);
      sel_source_o <= cur_dec;
    end
  end

  function automatic logic [2:0] osc_bit(input logic [2:0] src);
    case (src)
      SRC_EXT, SRC_EXT_PLL: osc_bit = 3'(OSC_EXT_BIT);
      SRC_LF: osc_bit = 3'(OSC_LF_BIT);
      SRC_SEC: osc_bit = 3'(OSC_SEC_BIT);
      default: osc_bit = 3'(OSC_HF_BIT);
    endcase
  endfunction : osc_bit

  // ---------------------------------------------------------------
  // system clock enable: stopped during gap, relock and sleep
  // ---------------------------------------------------------------
  assign run = (state_reg != ST_GAP) && (state_reg != ST_RELOCK) && (state_reg != ST_SLEEP);
  scs_post_div u_post_div (
    .clk_i(core_clk_i),
    .srst_i(srst_i),
    .run_i(run),
    .div_i(current_divider_o),
    .tick_o(div_tick)
  );
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sys_clk_en_o <= 1'b0;
    end else begin
      sys_clk_en_o <= div_tick && run;
    end
  end

  // ---------------------------------------------------------------
  // fixed internal clocks
  // ---------------------------------------------------------------
  scs_tick_div #(.HALF(MF_500K_HALF)) u_mf500 (
    .clk_i(core_clk_i),
    .srst_i(srst_i),
    .clk_o(mf_500k_o)
  );
  scs_tick_div #(.HALF(MF_32K_HALF)) u_mf32 (
    .clk_i(core_clk_i),
    .srst_i(srst_i),
    .clk_o(mf_32k_o)
  );
  scs_tick_div #(.HALF(LF_HALF)) u_lf31 (
    .clk_i(core_clk_i),
    .srst_i(srst_i),
    .clk_o(lf_31k_o)
  );
endmodule : scs_switcher
`default_nettype wire

// ---- tb/scs_switcher_monitor.sv ----
// Purpose: port-level checks for the clock source switcher
// Assumes: one core clock, synchronous active-high reset
// Notes: sees only top-level ports; attached by bind below
`timescale 1ns/1ps
`default_nettype none
module scs_switcher_monitor (
  input wire logic core_clk_i, // core clock
  input wire logic srst_i, // sync reset
  input wire logic switch_enable_config_i, // request writable
  input wire logic req_wr_i, // request write strobe
  input wire logic [2:0] requested_source_i, // written source
  input wire logic [3:0] requested_divider_i, // written divider
  input wire logic irq_enable_i, // irq enable
  input wire logic [2:0] requested_source_o, // request source
  input wire logic [3:0] requested_divider_o, // request divider
  input wire logic [2:0] current_source_o, // current source
  input wire logic [3:0] current_divider_o, // current divider
  input wire logic switch_hold_o, // hold bit
  input wire logic new_source_ready_o, // new ready bit
  input wire logic switch_done_o, // done bit
  input wire logic switch_irq_flag_o, // irq flag
  input wire logic irq_o, // interrupt
  input wire logic [5:0] freq_trim_o // trim value
);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  trim_rst_a: assert property (
    $past(srst_i) |-> freq_trim_o == 6'h00) else $error("trim not zero after reset");
  cfg_lock_a: assert property (
    req_wr_i && !switch_enable_config_i |=> $stable(requested_source_o)
    && $stable(requested_divider_o)) else $error("request changed while locked");
  rsv_skip_a: assert property (
    req_wr_i && (requested_source_i == 3'h0 || requested_source_i == 3'h3)
    |=> $stable(requested_source_o) && $stable(requested_divider_o))
    else $error("reserved request was taken");
  req_take_a: assert property (
    req_wr_i && switch_enable_config_i && requested_source_i != 3'h0
    && requested_source_i != 3'h3 && requested_divider_i <= 4'h9
    |=> requested_source_o == $past(requested_source_i)
    && requested_divider_o == $past(requested_divider_i)) else $error("request not taken");
  hold_stay_a: assert property (
    switch_hold_o && new_source_ready_o |=> $stable(current_source_o)
    && $stable(current_divider_o)) else $error("switch made while held");
  done_match_a: assert property (
    $rose(switch_done_o) |-> current_source_o == requested_source_o
    && current_divider_o == requested_divider_o && !new_source_ready_o)
    else $error("done without matching fields");
  ready_flag_a: assert property (
    $rose(new_source_ready_o) |-> switch_irq_flag_o) else $error("ready without flag");
  irq_follow_a: assert property (
    irq_enable_i && switch_irq_flag_o |=> irq_o) else $error("interrupt missing");
  // main scenarios reached
  held_c: cover property (switch_hold_o && new_source_ready_o);
  done_c: cover property ($rose(switch_done_o));
  irq_c: cover property (irq_o);
endmodule : scs_switcher_monitor
bind scs_switcher scs_switcher_monitor u_mon (.core_clk_i, .srst_i, .switch_enable_config_i,
  .req_wr_i, .requested_source_i, .requested_divider_i, .irq_enable_i, .requested_source_o,
  .requested_divider_o, .current_source_o, .current_divider_o, .switch_hold_o,
  .new_source_ready_o, .switch_done_o, .switch_irq_flag_o, .irq_o, .freq_trim_o);
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the clock source switcher
// Assumes: oscillators modelled by ready levels, short relock count
// Notes: request table first, then hold, lock, trim and sleep cases
`timescale 1ns/1ps
`default_nettype none
module tb;
  import scs_pkg::*;
  logic clk = 0, rst = 1, cfg = 1, rw = 0, hw = 0, hv = 0, ie = 0, fc = 0, tw = 0;
  logic sl = 0, wk = 0, fw = 0, lk = 1, nr, dn, fl, irq, asl, ce;
  logic [2:0] src = 3'h0, es = 3'h6, hs = 3'h0, rq, cs, hf, sel;
  logic [3:0] dv = 4'h0, ed = 4'h2, cd, rd;
  logic [5:0] tv = 6'h00, tr;
  logic [7:0] rdy = 8'hff, ost, nce = 8'h00;
  int n_errors = 0, n_checks = 0;
  // rows: source, divider, accepted
  logic [7:0] rows [10] = '{8'he1, 8'hb3, 8'h02, 8'h62, 8'h87, 8'h94, 8'h8b, 8'h41, 8'h21,
    8'hc5};
  scs_switcher #(.LOCK_CYC(2)) DUT (.core_clk_i(clk), .srst_i(rst),
    .reset_source_select_i(3'h6), .switch_enable_config_i(cfg), .req_wr_i(rw),
    .requested_source_i(src), .requested_divider_i(dv), .hold_wr_i(hw), .switch_hold_i(hv),
    .irq_enable_i(ie), .irq_flag_clr_i(fc), .trim_wr_i(tw), .freq_trim_i(tv), .frq_wr_i(fw),
    .hf_freq_select_i(hs), .osc_manual_enable_i(8'h00), .osc_ready_i(rdy), .pll_lock_i(lk),
    .doze_i(1'b0), .sleep_i(sl), .wake_i(wk), .requested_source_o(rq),
    .requested_divider_o(rd), .current_source_o(cs), .current_divider_o(cd),
    .switch_hold_o(), .new_source_ready_o(nr), .switch_done_o(dn), .switch_irq_flag_o(fl),
    .irq_o(irq), .freq_trim_o(tr), .hf_freq_o(hf), .osc_ready_status_o(ost), .osc_enable_o(),
    .sel_source_o(sel), .sys_clk_en_o(ce), .mf_500k_o(), .mf_32k_o(), .lf_31k_o(),
    .pll_fail_o(), .asleep_o(asl));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tick();
    @(posedge clk);
    #2;
  endtask : tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // write then let the state leave idle before polling
  task automatic req(input logic [2:0] s, input logic [3:0] d);
    src = s;
    dv = d;
    rw = 1;
    tick();
    rw = 0;
    tick();
    tick();
  endtask : req
  // bounded poll of ready (1) or done (0)
  task automatic wait_on(input bit r);
    int k;
    k = 0;
    while ((r ? nr : dn) !== 1'b1 && k < 300) begin
      tick();
      k++;
    end
    if (k == 300) chk(8'h00, 8'h01);
  endtask : wait_on
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // ---------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial forever #20 clk = ~clk;
  // whole run is about a hundred cycles; allow 5000 cycles, some fifty times that
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (6) tick();
    rst = 0;
    tick();
    chk(cs, 3'h6);
    chk(cd, 4'h2);
    chk(tr, 6'h00);
    chk(hf, HF_FRQ_1MHZ);
    foreach (rows[i]) begin
      req(rows[i][7:5], rows[i][4:1]);
      if (rows[i][0]) begin
        es = rows[i][7:5];
        ed = rows[i][4:1];
      end
      wait_on(0);
      tick();
      chk(cs, es);
      chk(sel, es);
      chk(cd, ed);
      chk(rq, es);
      chk(rd, ed);
    end
    ie = 1;
    hv = 1;
    hw = 1;
    tick();
    hw = 0;
    req(3'h5, 4'h1);
    wait_on(1);
    // old clock keeps running while held: ratio 4 gives two enables in eight cycles
    repeat (8) begin
      tick();
      nce = nce + 8'(ce);
    end
    chk(nce, 8'h02);
    chk(cs, 3'h6);
    chk(fl, 1'b1);
    chk(irq, 1'b1);
    hv = 0;
    hw = 1;
    tick();
    hw = 0;
    wait_on(0);
    chk(cs, 3'h5);
    chk(nr, 1'b0);
    // held switch abandoned by copying current back into the request
    hv = 1;
    hw = 1;
    tick();
    hw = 0;
    req(3'h7, 4'h0);
    wait_on(1);
    req(3'h5, 4'h1);
    wait_on(0);
    chk(cs, 3'h5);
    chk(nr, 1'b0);
    hv = 0;
    hw = 1;
    tick();
    hw = 0;
    fc = 1;
    tick();
    fc = 0;
    tick();
    chk(fl, 1'b0);
    cfg = 0;
    req(3'h7, 4'h0);
    chk(rq, 3'h5);
    cfg = 1;
    tv = 6'h20;
    tw = 1;
    hs = 3'h7;
    fw = 1;
    lk = 0;
    tick();
    tw = 0;
    fw = 0;
    tick();
    chk(tr, 6'h20);
    chk(dn, 1'b1);
    chk(hf, HF_FRQ_MAX);
    tick();
    chk(ost, 8'hfe);
    lk = 1;
    rdy = 8'h7f;
    req(3'h7, 4'h0);
    sl = 1;
    tick();
    tick();
    chk(asl, 1'b1);
    chk(cs, 3'h5);
    rdy = 8'hff;
    sl = 0;
    repeat (3) tick();
    wk = 1;
    tick();
    wk = 0;
    wait_on(0);
    chk(cs, 3'h7);
    chk(fl, 1'b1);
    // mid-run reset brings back the strap source and clears the flag
    rst = 1;
    tick();
    rst = 0;
    tick();
    chk(cs, 3'h6);
    chk(fl, 1'b0);
    chk(tr, 6'h00);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
